// ==== fpc_regs.vh ====
/*
  Constants for the pseudo-SRAM nonvolatile memory host port: geometry,
  command codes and cycle timing at a 100 MHz system clock.
  Assumes it is included by bare name from the host controller files.
*/
`ifndef FPC_REGS_VH
`define FPC_REGS_VH

`define FPC_ADDR_W 18
`define FPC_DATA_W 16
`define FPC_WORDS 262144
`define FPC_CLK_NS 10
// Cycle time, chip-select active time, precharge time and strobe width in ns.
`define FPC_CYCLE_NS 150
`define FPC_ACTIVE_NS 75
`define FPC_PRECHARGE_NS 75
`define FPC_STROBE_NS 20
// Least times round up to whole clock cycles.
`define FPC_CYCLES(ns) (((ns) + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_ACTIVE_CYC `FPC_CYCLES(`FPC_CYCLE_NS)
`define FPC_PRECHARGE_CYC `FPC_CYCLES(`FPC_PRECHARGE_NS)
`define FPC_STROBE_CYC `FPC_CYCLES(`FPC_STROBE_NS)
`define FPC_CNT_W 8
// Command codes on the user port.
`define FPC_CMD_READ 2'h0
`define FPC_CMD_WRITE 2'h1
`define FPC_CMD_CLEAR 2'h2

`endif

// ==== fpc_timer.v ====
/*
  Down counter that times each phase of a memory access.
  Assumes a synchronous active-high reset on the shared clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fpc_regs.vh"

module fpc_timer #(
  parameter CNT_W = `FPC_CNT_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [CNT_W-1:0] value_i,
  output wire done_o
);
  reg [CNT_W-1:0] count;

  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= {CNT_W{1'b0}};
    end else if (load_i) begin
      count <= value_i;
    end else if (count != {CNT_W{1'b0}}) begin
      count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign done_o = (count == {CNT_W{1'b0}});
endmodule

`default_nettype wire

// ==== fpc_host.v ====
/*
  Host controller that drives a 256K x 16 nonvolatile pseudo-SRAM over its
  asynchronous pins: chip-select controlled reads and writes, byte lanes,
  precharge spacing and the array-clear input.
  Assumes a single 100 MHz clock; pin inputs are synchronous to it and the
  board resolves the data bus from the output enable.
*/
// Functional notes
// (R1) 262,144 words selected by 18-bit address.
// (R2) Address change under select starts a read.
// (R3) One 16-bit two-way data bus.
// (R4) Access only with select low, clear high.
// (R5) Select rising edge latches write data.
// (R6) Write starts strobe fall, latched strobe rise.
// (R7) Output enable low drives read data.
// (R8) Clear input low zeroes whole array.
// (R9) Host holds clear high during accesses.
// (R10) Low lanes enable their byte halves.
// (R11) Both lanes high: no data, no write.
// (R12) Data latched at earlier rising edge.
// (R13) Strobe write may show read data briefly.
// (R14) Address-change write may show read data.
// (R15) Unused byte lanes are held low.
// (R16) Precharge follows select rise before next access.
// (R17) Select high means standby, pins ignored.
`timescale 1ns/1ns
`default_nettype none
`include "fpc_regs.vh"

module fpc_host #(
  parameter ADDR_W = `FPC_ADDR_W,
  parameter DATA_W = `FPC_DATA_W,
  parameter CNT_W = `FPC_CNT_W,
  parameter [CNT_W-1:0] ACTIVE_CYC = `FPC_ACTIVE_CYC,
  parameter [CNT_W-1:0] PRECHARGE_CYC = `FPC_PRECHARGE_CYC,
  parameter [CNT_W-1:0] STROBE_CYC = `FPC_STROBE_CYC,
  parameter [CNT_W-1:0] CLEAR_CYC = `FPC_PRECHARGE_CYC
) (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire REQ_VALID_I,
  input wire [1:0] REQ_CMD_I,
  input wire [ADDR_W-1:0] REQ_ADDR_I,
  input wire [DATA_W-1:0] REQ_WDATA_I,
  input wire [1:0] REQ_BYTE_EN_I,
  output reg REQ_READY_O,
  output reg RSP_VALID_O,
  output reg [DATA_W-1:0] RSP_RDATA_O,
  output reg [ADDR_W-1:0] MEM_ADDR_O,
  output reg MEM_CHIP_SEL_N_O,
  output reg MEM_WRITE_N_O,
  output reg MEM_OUT_EN_N_O,
  output reg MEM_LOW_BYTE_LANE_N_O,
  output reg MEM_HIGH_BYTE_LANE_N_O,
  output reg MEM_CLEAR_N_O,
  input wire [DATA_W-1:0] MEM_DATA_I,
  output reg [DATA_W-1:0] MEM_DATA_O,
  output reg MEM_DATA_OE_O
);
  // ==========================================================================
  // State machine
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_READ = 5'h02;
  localparam [4:0] ST_WRITE = 5'h04;
  localparam [4:0] ST_PRECHARGE = 5'h08;
  localparam [4:0] ST_CLEAR = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg timer_load;
  reg [CNT_W-1:0] timer_value;
  reg strobe_high;
  wire timer_done;

  fpc_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(timer_load),
    .value_i(timer_value),
    .done_o(timer_done)
  );

  // Both lanes high would move no data, so a zero mask is promoted to a
  // whole word; boards that never use byte access see both lanes low.
  function [1:0] fpc_lanes_n;
    input [1:0] byte_en;
    begin
      if (byte_en == 2'h0) begin
        fpc_lanes_n = 2'h0; // R15
      end else begin
        fpc_lanes_n = ~byte_en; // R10 R11
      end
    end
  endfunction

  wire take = REQ_VALID_I && REQ_READY_O;

  always @* begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = ACTIVE_CYC;
    case (state)
      ST_IDLE: begin
        if (take) begin
          timer_load = 1'b1;
          if (REQ_CMD_I == `FPC_CMD_CLEAR) begin
            next_state = ST_CLEAR;
            timer_value = CLEAR_CYC;
          end else if (REQ_CMD_I == `FPC_CMD_WRITE) begin
            next_state = ST_WRITE;
          end else begin
            next_state = ST_READ;
          end
        end
      end
      ST_READ, ST_WRITE: begin
        if (timer_done) begin
          next_state = ST_PRECHARGE; // R16
          timer_load = 1'b1;
          timer_value = PRECHARGE_CYC;
        end
      end
      ST_PRECHARGE, ST_CLEAR: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Pin drive
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state <= ST_IDLE;
      REQ_READY_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      RSP_RDATA_O <= 16'h0000;
      MEM_ADDR_O <= {ADDR_W{1'b0}};
      MEM_CHIP_SEL_N_O <= 1'b1;
      MEM_WRITE_N_O <= 1'b1;
      MEM_OUT_EN_N_O <= 1'b1;
      MEM_LOW_BYTE_LANE_N_O <= 1'b0;
      MEM_HIGH_BYTE_LANE_N_O <= 1'b0;
      MEM_CLEAR_N_O <= 1'b1;
      MEM_DATA_O <= 16'h0000;
      MEM_DATA_OE_O <= 1'b0;
      strobe_high <= 1'b0;
    end else begin
      state <= next_state;
      RSP_VALID_O <= 1'b0;
      REQ_READY_O <= (next_state == ST_IDLE);
      case (state)
        ST_IDLE: begin
          // Select stays high between accesses, so the part idles in
          // standby whatever the other pins do.
          MEM_CHIP_SEL_N_O <= 1'b1; // R17
          MEM_CLEAR_N_O <= 1'b1; // R9
          if (take) begin
            REQ_READY_O <= 1'b0;
            strobe_high <= 1'b0;
            // Address is set in the same edge as select falls: setup is 0 ns.
            MEM_ADDR_O <= REQ_ADDR_I; // R1 R2
            {MEM_HIGH_BYTE_LANE_N_O, MEM_LOW_BYTE_LANE_N_O} <= fpc_lanes_n(REQ_BYTE_EN_I);
            if (REQ_CMD_I == `FPC_CMD_CLEAR) begin
              MEM_CLEAR_N_O <= 1'b0; // R8
            end else if (REQ_CMD_I == `FPC_CMD_WRITE) begin
              // Strobe falls with select; the bus stays undriven for the first cycle only
              // and is driven from the next edge until one cycle after the pulse ends.
              MEM_CHIP_SEL_N_O <= 1'b0; // R4
              MEM_WRITE_N_O <= 1'b0; // R6 R13 R14
              MEM_DATA_O <= REQ_WDATA_I;
            end else begin
              MEM_CHIP_SEL_N_O <= 1'b0; // R4
              MEM_OUT_EN_N_O <= 1'b0; // R7
            end
          end
        end
        ST_WRITE: begin
          MEM_DATA_OE_O <= 1'b1; // R3
          if (timer_done) begin
            // Strobe and select rise together; whichever the part sees first
            // latches the same stable data.
            MEM_WRITE_N_O <= 1'b1; // R5 R6 R12
            MEM_CHIP_SEL_N_O <= 1'b1;
          end
        end
        ST_READ: begin
          if (timer_done) begin
            RSP_RDATA_O <= MEM_DATA_I; // R7
            RSP_VALID_O <= 1'b1;
            MEM_OUT_EN_N_O <= 1'b1;
            MEM_CHIP_SEL_N_O <= 1'b1;
          end
        end
        ST_PRECHARGE: begin
          // Data is held one cycle past the rising edges for hold time.
          MEM_DATA_OE_O <= 1'b0;
          strobe_high <= 1'b1;
        end
        ST_CLEAR: begin
          if (timer_done) begin
            MEM_CLEAR_N_O <= 1'b1; // R8
          end
        end
        default: begin
          MEM_CHIP_SEL_N_O <= 1'b1;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== fpc_mem_model.sv ====
/* Behavioural model of the nonvolatile memory behind the host port.
   Assumes the bench resolves the shared data bus from both drivers. */
`timescale 1ns/1ns
`default_nettype none
module fpc_mem_model #(
  parameter int DLY = 75
) (
  input wire logic [17:0] a_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic lb_n_i,
  input wire logic ub_n_i,
  input wire logic clr_n_i,
  input wire logic [15:0] d_i,
  output var logic [15:0] q_o,
  output logic [1:0] drv_o
);
  // ==========
  // Array
  logic [15:0] mem [bit [17:0]];
  logic [15:0] old;
  logic wip = 0;
  always @(negedge clr_n_i) mem.delete();
  always @(negedge we_n_i or negedge ce_n_i) wip = !ce_n_i && !we_n_i && clr_n_i;
  always @(posedge ce_n_i or posedge we_n_i) if (wip) begin
    wip = 0;
    old = mem.exists(a_i) ? mem[a_i] : 16'h0000;
    mem[a_i] = {ub_n_i ? old[15:8] : d_i[15:8], lb_n_i ? old[7:0] : d_i[7:0]};
  end
  // ==========
  // Read path
  // Data is scrambled until the access time runs out, so an early sample fails.
  always @(a_i or ce_n_i or oe_n_i or we_n_i or clr_n_i) begin
    q_o = ~q_o;
    q_o <= #DLY mem.exists(a_i) ? mem[a_i] : 16'h0000;
  end
  assign drv_o = {2{!ce_n_i && !oe_n_i && we_n_i && clr_n_i}} & ~{ub_n_i, lb_n_i};
endmodule
`default_nettype wire

// ==== fpc_host_props.sv ====
/* Checker on the host controller pins.
   Assumes it is bound to fpc_host with the default parameters. */
`timescale 1ns/1ns
`default_nettype none
module fpc_host_props (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic REQ_VALID_I,
  input wire logic REQ_READY_O,
  input wire logic [1:0] REQ_CMD_I,
  input wire logic [1:0] REQ_BYTE_EN_I,
  input wire logic [17:0] REQ_ADDR_I,
  input wire logic RSP_VALID_O,
  input wire logic [17:0] MEM_ADDR_O,
  input wire logic MEM_CHIP_SEL_N_O,
  input wire logic MEM_OUT_EN_N_O,
  input wire logic MEM_LOW_BYTE_LANE_N_O,
  input wire logic MEM_HIGH_BYTE_LANE_N_O,
  input wire logic MEM_CLEAR_N_O,
  input wire logic MEM_DATA_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire tk = REQ_VALID_I && REQ_READY_O;
  // ==========
  // Properties
  a_clear_held_access: assert property (!MEM_CHIP_SEL_N_O |-> MEM_CLEAR_N_O)
    else $error("clear low during access");
  a_precharge_gap: assert property ($rose(MEM_CHIP_SEL_N_O) |-> MEM_CHIP_SEL_N_O[*8])
    else $error("select low within precharge");
  a_full_word_lanes: assert property (tk && REQ_BYTE_EN_I == 2'h0 && REQ_CMD_I != 2'h2
    |=> !MEM_LOW_BYTE_LANE_N_O && !MEM_HIGH_BYTE_LANE_N_O) else $error("lane high on word");
  a_no_bus_fight: assert property (!MEM_OUT_EN_N_O |-> !MEM_DATA_OE_O)
    else $error("host drives during read");
  a_read_answer: assert property (tk && REQ_CMD_I != 2'h1 && REQ_CMD_I != 2'h2
    |-> ##[16:17] RSP_VALID_O) else $error("read answer late");
  a_addr_presented: assert property (tk && REQ_CMD_I != 2'h2
    |=> MEM_ADDR_O == $past(REQ_ADDR_I)) else $error("address not presented");
  c_write: cover property (tk && REQ_CMD_I == 2'h1);
  c_read: cover property (tk && REQ_CMD_I == 2'h0);
  c_clear: cover property (tk && REQ_CMD_I == 2'h2);
endmodule
bind fpc_host fpc_host_props u_fpc_host_props (.CLK_I, .SYS_RST_I, .REQ_VALID_I,
  .REQ_READY_O, .REQ_CMD_I, .REQ_BYTE_EN_I, .REQ_ADDR_I, .RSP_VALID_O, .MEM_ADDR_O,
  .MEM_CHIP_SEL_N_O, .MEM_OUT_EN_N_O, .MEM_LOW_BYTE_LANE_N_O, .MEM_HIGH_BYTE_LANE_N_O,
  .MEM_CLEAR_N_O, .MEM_DATA_OE_O);
`default_nettype wire

// ==== fpc_host_tb_top.sv ====
/* Self-checking bench for the host controller with a memory model.
   Assumes the default timing parameters of the controller. */
`timescale 1ns/1ns
`default_nettype none
module fpc_host_tb_top;
  logic CLK_I = 0, SYS_RST_I = 1, REQ_VALID_I = 0;
  logic [1:0] REQ_CMD_I = 0, REQ_BYTE_EN_I = 0, drv;
  logic [17:0] REQ_ADDR_I = 0, MEM_ADDR_O;
  logic [15:0] REQ_WDATA_I = 0, RSP_RDATA_O, MEM_DATA_I, MEM_DATA_O, md, m, prv = 0;
  logic REQ_READY_O, RSP_VALID_O, MEM_CHIP_SEL_N_O, MEM_WRITE_N_O, MEM_OUT_EN_N_O;
  logic MEM_LOW_BYTE_LANE_N_O, MEM_HIGH_BYTE_LANE_N_O, MEM_CLEAR_N_O, MEM_DATA_OE_O;
  logic [15:0] shadow [bit [17:0]];
  int fail_count = 0, compares = 0, cyc = 0;
  initial forever #5 CLK_I = ~CLK_I;
  // Released bits show the inverse of last cycle, so a stale bus never matches.
  assign m = {{8{drv[1]}}, {8{drv[0]}}};
  assign MEM_DATA_I = MEM_DATA_OE_O ? MEM_DATA_O : (md & m) | (~prv & ~m);
  always @(posedge CLK_I) prv <= MEM_DATA_I;
  fpc_host u_fpc_host (.CLK_I, .SYS_RST_I, .REQ_VALID_I, .REQ_CMD_I, .REQ_ADDR_I,
    .REQ_WDATA_I, .REQ_BYTE_EN_I, .REQ_READY_O, .RSP_VALID_O, .RSP_RDATA_O, .MEM_ADDR_O,
    .MEM_CHIP_SEL_N_O, .MEM_WRITE_N_O, .MEM_OUT_EN_N_O, .MEM_LOW_BYTE_LANE_N_O,
    .MEM_HIGH_BYTE_LANE_N_O, .MEM_CLEAR_N_O, .MEM_DATA_I, .MEM_DATA_O, .MEM_DATA_OE_O);
  fpc_mem_model u_fpc_mem_model (.a_i(MEM_ADDR_O), .ce_n_i(MEM_CHIP_SEL_N_O),
    .we_n_i(MEM_WRITE_N_O), .oe_n_i(MEM_OUT_EN_N_O), .lb_n_i(MEM_LOW_BYTE_LANE_N_O),
    .ub_n_i(MEM_HIGH_BYTE_LANE_N_O), .clr_n_i(MEM_CLEAR_N_O), .d_i(MEM_DATA_I),
    .q_o(md), .drv_o(drv));
  // ==========
  // Tasks
  function automatic logic [15:0] rd(input logic [17:0] a);
    return shadow.exists(a) ? shadow[a] : 16'h0000;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic req(input logic [1:0] c, input logic [17:0] a, input logic [15:0] d,
    input logic [1:0] be);
    logic [15:0] k;
    k = be == 2'h0 ? 16'hFFFF : {{8{be[1]}}, {8{be[0]}}};
    while (REQ_READY_O !== 1'b1) @(posedge CLK_I) #1;
    {REQ_VALID_I, REQ_CMD_I, REQ_ADDR_I, REQ_WDATA_I, REQ_BYTE_EN_I} = {1'b1, c, a, d, be};
    @(posedge CLK_I) #1;
    REQ_VALID_I = 0;
    if (c == 2'h1) shadow[a] = (d & k) | (rd(a) & ~k);
    if (c == 2'h2) shadow.delete();
    if (c == 2'h0) begin
      while (RSP_VALID_O !== 1'b1) @(posedge CLK_I) #1;
      chk(RSP_RDATA_O & k, rd(a) & k);
    end
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========
  // Tests
  initial begin
    void'($urandom(32'hce079e95));
    repeat (6) @(posedge CLK_I);
    #1 SYS_RST_I = 0;
    req(1, 18'h3FFFF, 16'hA5C3, 0);
    req(0, 18'h3FFFF, 0, 0);
    req(1, 18'h3FFFF, 16'h1234, 1);
    req(0, 18'h3FFFF, 0, 3);
    req(1, 18'h3FFFF, 16'h5678, 2);
    req(0, 18'h3FFFF, 0, 1);
    $display("test 1 done");
    for (int i = 0; i < 60; i++) begin
      req($urandom % 2, ($urandom % 2) ? $urandom % 4 : 18'h3FFFC + $urandom % 4, $urandom,
        $urandom % 4);
    end
    $display("test 2 done");
    req(2, 0, 0, 0);
    req(0, 18'h3FFFF, 0, 0);
    req(0, 18'h3FFFC, 0, 0);
    $display("test 3 done");
    give_verdict();
  end
endmodule
`default_nettype wire
